// ---- inc/sag_pkg.sv ----
// constants and types for the setup access gate
// assumes a 40 MHz system clock and debounced-free raw button pins
package sag_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;  // system clock rate
  localparam int unsigned HOLD_MS       = 3000;        // easy route hold time
  localparam int unsigned PIN_WIN_MS    = 2000;        // pin start window
  localparam int unsigned MSG_MS        = 1000;        // message show time
  localparam int unsigned HOLD_CYC_DFLT = (CLK_HZ / 1000) * HOLD_MS;
  localparam int unsigned WIN_CYC_DFLT  = (CLK_HZ / 1000) * PIN_WIN_MS;
  localparam int unsigned MSG_CYC_DFLT  = (CLK_HZ / 1000) * MSG_MS;
  localparam int unsigned CNT_W         = 28;          // timer width

  // ----------------------------------------------------------------
  // access levels
  // ----------------------------------------------------------------
  localparam logic [2:0] LVL_NONE = 3'h0;  // no access
  localparam logic [2:0] LVL_FULL = 3'h7;  // full operation level
  localparam logic [3:0] OVR_DFLT = 4'h0;  // default level choice

  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_EASY_LVL = 6'h00;
  localparam logic [5:0] OFS_RMT_LVL  = 6'h04;
  localparam logic [5:0] OFS_PIN1_VAL = 6'h08;
  localparam logic [5:0] OFS_PIN1_LVL = 6'h0c;
  localparam logic [5:0] OFS_PIN2_VAL = 6'h10;
  localparam logic [5:0] OFS_PIN2_LVL = 6'h14;
  localparam logic [5:0] OFS_STATUS   = 6'h18;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h1c;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h20;
  localparam logic [5:0] OFS_OVR_BASE = 6'h24;  // slots at base + 4*i
  localparam int unsigned N_OVR        = 6;      // override slots

  // reset values
  localparam logic [15:0] PIN_RST  = 16'h0000;
  localparam logic [15:0] FNUM_RST = 16'h0000;

  // interrupt bits
  localparam int unsigned IRQ_GRANT  = 0;
  localparam int unsigned IRQ_REFUSE = 1;
  localparam int unsigned IRQ_W      = 2;

  // route codes shown in status
  localparam logic [1:0] RT_EASY   = 2'h0;
  localparam logic [1:0] RT_REMOTE = 2'h1;
  localparam logic [1:0] RT_PIN    = 2'h2;

  // states
  typedef enum logic [6:0] {
    SAG_IDLE   = 7'b000_0001,
    SAG_HOLD   = 7'b000_0010,
    SAG_WIN    = 7'b000_0100,
    SAG_PROMPT = 7'b000_1000,
    SAG_ENTRY  = 7'b001_0000,
    SAG_REFUSE = 7'b010_0000,
    SAG_OPEN   = 7'b100_0000
  } sag_state_e;

endpackage : sag_pkg

// ---- logic/sag_gate.sv ----
// setup access gate: routes of entry, pin check, level grant, bus slave
// assumes raw button and remote pins, avalon-mm master on clk
`timescale 1ns/1ps
`default_nettype none

module sag_gate
  import sag_pkg::*;
#(
  parameter int unsigned HOLD_CYC = HOLD_CYC_DFLT,  // easy hold cycles
  parameter int unsigned WIN_CYC  = WIN_CYC_DFLT,   // pin window cycles
  parameter int unsigned MSG_CYC  = MSG_CYC_DFLT    // message cycles
)(
  input  wire logic        clk,              // system clock
  input  wire logic        rst,              // async reset, high
  input  wire logic [5:0]  avs_address,      // byte address
  input  wire logic        avs_read,         // read strobe
  input  wire logic        avs_write,        // write strobe
  input  wire logic [31:0] avs_writedata,    // write data
  input  wire logic [3:0]  avs_byteenable,   // byte lanes
  output logic      [31:0] avs_readdata,     // read data
  output logic             avs_waitrequest,  // stall
  input  wire logic        btn_setup_entry_message,         // function button pin
  input  wire logic        btn_up,           // up adjust pin
  input  wire logic        btn_down,         // down adjust pin
  input  wire logic        remote_access_n,  // remote input, low active
  input  wire logic [15:0] query_fnum,       // function asked by menu
  output logic             query_ok,         // asked function permitted
  output logic             setup_entry_message,   // entry message shown
  output logic             setup_refused_message, // refusal shown
  output logic             code_prompt,      // code prompt shown
  output logic [15:0]      code_value,       // value being entered
  output logic             setup_open,       // setup menu active
  output logic [2:0]       granted_level,    // level in force
  output logic             irq               // level interrupt
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_q;  // first stage, read only by second
  logic [3:0] sync2_q;  // second stage
  logic [3:0] prev_q;   // for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q  <= 4'h0;
    end else begin
      sync1_q <= {~remote_access_n, btn_down, btn_up, btn_setup_entry_message};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  logic f_lvl, u_lvl, d_lvl, rmt;  // synced levels
  logic f_rise, f_fall, u_rise, d_rise;
  assign f_lvl  = sync2_q[0];
  assign u_lvl  = sync2_q[1];
  assign d_lvl  = sync2_q[2];
  assign rmt    = sync2_q[3];
  assign f_rise = f_lvl & ~prev_q[0];
  assign f_fall = ~f_lvl & prev_q[0];
  assign u_rise = u_lvl & ~prev_q[1];
  assign d_rise = d_lvl & ~prev_q[2];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [2:0]  easy_route_level_q;    // easy route level
  logic [2:0]  remote_route_level_q;  // remote route level
  logic [15:0] first_pin_value_q;     // first pin
  logic [2:0]  first_pin_level_q;     // first pin level
  logic [15:0] second_pin_value_q;    // second pin
  logic [2:0]  second_pin_level_q;    // second pin level
  logic [IRQ_W-1:0] irq_stat_q;       // sticky events
  logic [IRQ_W-1:0] irq_mask_q;       // event enables
  logic [16*N_OVR-1:0] ovr_fnum_q;    // override function numbers
  logic [4*N_OVR-1:0]  ovr_lvl_q;     // override levels

  logic wr_hit, rd_hit;  // accepted bus access
  assign wr_hit = avs_write & ~avs_waitrequest;
  assign rd_hit = avs_read & ~avs_waitrequest;

  // write path, low lanes only as fields are narrow, except lane 2 for override levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      easy_route_level_q   <= LVL_NONE;
      remote_route_level_q <= LVL_NONE;
      first_pin_value_q    <= PIN_RST;
      first_pin_level_q    <= LVL_NONE;
      second_pin_value_q   <= PIN_RST;
      second_pin_level_q   <= LVL_NONE;
      irq_mask_q           <= '0;
      ovr_fnum_q           <= '0;
      ovr_lvl_q            <= '0;
    end else if (wr_hit) begin
      case (avs_address)
        OFS_EASY_LVL: if (avs_byteenable[0]) easy_route_level_q <= avs_writedata[2:0];
        OFS_RMT_LVL:  if (avs_byteenable[0]) remote_route_level_q <= avs_writedata[2:0];
        OFS_PIN1_VAL: begin
          if (avs_byteenable[0]) first_pin_value_q[7:0]  <= avs_writedata[7:0];
          if (avs_byteenable[1]) first_pin_value_q[15:8] <= avs_writedata[15:8];
        end
        OFS_PIN1_LVL: if (avs_byteenable[0]) first_pin_level_q <= avs_writedata[2:0];
        OFS_PIN2_VAL: begin
          if (avs_byteenable[0]) second_pin_value_q[7:0]  <= avs_writedata[7:0];
          if (avs_byteenable[1]) second_pin_value_q[15:8] <= avs_writedata[15:8];
        end
        OFS_PIN2_LVL: if (avs_byteenable[0]) second_pin_level_q <= avs_writedata[2:0];
        OFS_IRQ_MASK: if (avs_byteenable[0]) irq_mask_q <= avs_writedata[IRQ_W-1:0];
        default: begin
          // override slots: low half number, bits 19:16 level
          for (int i = 0; i < N_OVR; i++) begin
            if (avs_address == OFS_OVR_BASE + 6'(4*i)) begin
              if (avs_byteenable[0]) ovr_fnum_q[16*i +: 8]     <= avs_writedata[7:0];
              if (avs_byteenable[1]) ovr_fnum_q[16*i + 8 +: 8] <= avs_writedata[15:8];
              if (avs_byteenable[2]) ovr_lvl_q[4*i +: 4]       <= avs_writedata[19:16];
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // access state machine
  // ----------------------------------------------------------------
  sag_state_e    state_q;      // current state
  logic [CNT_W-1:0] tmr_q;     // state timer
  logic [15:0]   entry_q;      // code being entered
  logic [2:0]    lvl_q;        // granted level
  logic [1:0]    route_q;      // route last used
  logic          ev_grant, ev_refuse;  // one-cycle events
  logic [2:0]    pin_lvl;      // level from entered code

  // pin compare: zero pin matches any typed code, first wins
  always_comb begin
    pin_lvl = LVL_NONE;
    if (first_pin_value_q == PIN_RST || entry_q == first_pin_value_q) begin
      pin_lvl = first_pin_level_q;
    end else if (second_pin_value_q == PIN_RST || entry_q == second_pin_value_q) begin
      pin_lvl = second_pin_level_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= SAG_IDLE;
      tmr_q     <= '0;
      entry_q   <= '0;
      lvl_q     <= LVL_NONE;
      route_q   <= RT_EASY;
      ev_grant  <= 1'b0;
      ev_refuse <= 1'b0;
    end else begin
      ev_grant  <= 1'b0;
      ev_refuse <= 1'b0;
      tmr_q     <= tmr_q + 1'b1;
      case (state_q)
        SAG_IDLE: begin
          tmr_q <= '0;
          if (f_rise) begin
            state_q <= SAG_HOLD;
          end
        end
        SAG_HOLD: begin
          if (f_fall) begin
            // short tap opens the pin window
            state_q <= SAG_WIN;
            tmr_q   <= '0;
          end else if (tmr_q == CNT_W'(HOLD_CYC - 1)) begin
            // remote grounded selects the remote level
            route_q <= rmt ? RT_REMOTE : RT_EASY;
            lvl_q   <= rmt ? remote_route_level_q : easy_route_level_q;
            tmr_q   <= '0;
            if ((rmt ? remote_route_level_q : easy_route_level_q) == LVL_NONE) begin
              state_q   <= SAG_REFUSE;
              ev_refuse <= 1'b1;
            end else begin
              state_q  <= SAG_ENTRY;
              ev_grant <= 1'b1;
            end
          end
        end
        SAG_WIN: begin
          if (u_lvl && d_lvl) begin
            route_q <= RT_PIN;
            tmr_q   <= '0;
            entry_q <= '0;
            if (first_pin_level_q == LVL_NONE && second_pin_level_q == LVL_NONE) begin
              state_q   <= SAG_REFUSE;
              ev_refuse <= 1'b1;
            end else begin
              state_q <= SAG_PROMPT;
            end
          end else if (tmr_q == CNT_W'(WIN_CYC - 1)) begin
            state_q <= SAG_IDLE;  // window missed
          end
        end
        SAG_PROMPT: begin
          // adjust value, function accepts; hold comes first so accept clears
          if (tmr_q >= CNT_W'(MSG_CYC)) begin
            tmr_q <= tmr_q;  // hold timer at prompt
          end
          if (tmr_q < CNT_W'(MSG_CYC)) begin
            entry_q <= '0;  // entry message still showing
          end else if (f_rise) begin
            lvl_q <= pin_lvl;
            tmr_q <= '0;
            if (pin_lvl == LVL_NONE) begin
              state_q   <= SAG_REFUSE;
              ev_refuse <= 1'b1;
            end else begin
              state_q  <= SAG_OPEN;
              ev_grant <= 1'b1;
            end
          end else if (u_rise && !d_lvl) begin
            entry_q <= entry_q + 16'h0001;
          end else if (d_rise && !u_lvl) begin
            entry_q <= entry_q - 16'h0001;
          end
        end
        SAG_ENTRY: begin
          if (tmr_q == CNT_W'(MSG_CYC - 1)) begin
            state_q <= SAG_OPEN;  // first permitted function follows
          end
        end
        SAG_REFUSE: begin
          lvl_q <= LVL_NONE;
          if (tmr_q == CNT_W'(MSG_CYC - 1)) begin
            state_q <= SAG_IDLE;
          end
        end
        SAG_OPEN: begin
          // leave setup on a long function hold
          tmr_q <= f_lvl ? tmr_q + 1'b1 : '0;
          if (f_lvl && tmr_q == CNT_W'(HOLD_CYC - 1)) begin
            state_q <= SAG_IDLE;
            lvl_q   <= LVL_NONE;
          end
        end
        default: state_q <= SAG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per-function permission
  // ----------------------------------------------------------------
  logic [2:0] fn_lvl;   // effective function level
  logic       fn_known; // function exists
  sag_level_lut u_lut (
    .fnum      (query_fnum),
    .slot_fnum (ovr_fnum_q),
    .slot_lvl  (ovr_lvl_q),
    .lvl       (fn_lvl),
    .known     (fn_known)
  );

  // registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      query_ok              <= 1'b0;
      setup_entry_message   <= 1'b0;
      setup_refused_message <= 1'b0;
      code_prompt           <= 1'b0;
      code_value            <= '0;
      setup_open            <= 1'b0;
      granted_level         <= LVL_NONE;
    end else begin
      // level 1..n permitted, full level opens every known function of nonzero level
      query_ok <= (state_q == SAG_OPEN) && fn_known && (lvl_q != LVL_NONE)
               && (fn_lvl <= lvl_q) && (fn_lvl != LVL_NONE);
      setup_entry_message   <= (state_q == SAG_ENTRY)
                            || (state_q == SAG_PROMPT && tmr_q < CNT_W'(MSG_CYC));
      setup_refused_message <= (state_q == SAG_REFUSE);
      code_prompt           <= (state_q == SAG_PROMPT && tmr_q >= CNT_W'(MSG_CYC));
      code_value            <= entry_q;
      setup_open            <= (state_q == SAG_OPEN);
      granted_level         <= lvl_q;
    end
  end

  // ----------------------------------------------------------------
  // interrupts and bus read path
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;  // events this cycle
  logic [IRQ_W-1:0] irq_clr;  // write one to clear
  assign irq_set = {ev_refuse, ev_grant};
  assign irq_clr = (wr_hit && avs_address == OFS_IRQ_STAT && avs_byteenable[0])
                 ? avs_writedata[IRQ_W-1:0] : '0;

  // set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= '0;
      irq       <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq        <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
    end
  end

  // waitrequest low for one cycle per access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          OFS_EASY_LVL: avs_readdata <= {29'h0, easy_route_level_q};
          OFS_RMT_LVL:  avs_readdata <= {29'h0, remote_route_level_q};
          OFS_PIN1_VAL: avs_readdata <= {16'h0, first_pin_value_q};
          OFS_PIN1_LVL: avs_readdata <= {29'h0, first_pin_level_q};
          OFS_PIN2_VAL: avs_readdata <= {16'h0, second_pin_value_q};
          OFS_PIN2_LVL: avs_readdata <= {29'h0, second_pin_level_q};
          OFS_STATUS:   avs_readdata <= {19'h0, route_q, lvl_q, 1'b0, state_q};
          OFS_IRQ_STAT: avs_readdata <= {30'h0, irq_stat_q};
          OFS_IRQ_MASK: avs_readdata <= {30'h0, irq_mask_q};
          default: begin
            avs_readdata <= '0;  // unmapped reads zero
            for (int i = 0; i < N_OVR; i++) begin
              if (avs_address == OFS_OVR_BASE + 6'(4*i)) begin
                avs_readdata <= {12'h0, ovr_lvl_q[4*i +: 4], ovr_fnum_q[16*i +: 16]};
              end
            end
          end
        endcase
      end
    end
  end

  logic unused_rd;  // read strobe seen through readdata path
  assign unused_rd = rd_hit;

endmodule : sag_gate

`default_nettype wire

// ---- logic/sag_level_lut.sv ----
// per-function level lookup with override slots
// assumes default level table is a constant below; slots from parent
`timescale 1ns/1ps
`default_nettype none

module sag_level_lut
  import sag_pkg::*;
(
  input  wire logic [15:0]        fnum,       // function number asked
  input  wire logic [16*N_OVR-1:0] slot_fnum, // override function numbers
  input  wire logic [4*N_OVR-1:0]  slot_lvl,  // override levels
  output logic      [2:0]         lvl,        // effective level
  output logic                    known       // function exists
);

  // ----------------------------------------------------------------
  // default table of known functions
  // ----------------------------------------------------------------
  logic [2:0] dflt_lvl;  // original default level
  always_comb begin
    known    = 1'b1;
    dflt_lvl = LVL_FULL;
    case (fnum)
      16'h4482, 16'h0430, 16'h4376, 16'h4480, 16'h4484, 16'h4858,
      16'h4853, 16'h4856: dflt_lvl = 3'h4;
      16'h22fc, 16'h3355: dflt_lvl = 3'h2;
      16'h43a0:           dflt_lvl = 3'h5;
      16'h0c00, 16'h0c01, 16'h0c09, 16'h0c02, 16'h0c0a, 16'h0c03,
      16'h0c10, 16'h0c11, 16'h0c12, 16'h0c13, 16'h0c14, 16'h0c15,
      16'h0640, 16'h0641, 16'h0642, 16'h0643, 16'h0644,
      16'h0645:           dflt_lvl = LVL_FULL;
      default:            known    = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // override match per slot, last match wins
  // ----------------------------------------------------------------
  logic [N_OVR-1:0] hit;  // slot matches this function
  genvar gi;
  generate
    for (gi = 0; gi < N_OVR; gi = gi + 1) begin : g_slot
      assign hit[gi] = known && (fnum != 16'h0000)
                    && (slot_fnum[16*gi +: 16] == fnum)
                    && (slot_lvl[4*gi +: 4] != OVR_DFLT);
    end
  endgenerate

  always_comb begin
    lvl = dflt_lvl;
    for (int i = 0; i < N_OVR; i++) begin
      if (hit[i]) begin
        lvl = slot_lvl[4*i +: 3];
      end
    end
  end

endmodule : sag_level_lut

`default_nettype wire

// ---- verification/sag_assertions.sv ----
// port checker for the setup access gate
// assumes one clock domain and a bind onto sag_gate
`timescale 1ns/1ps
`default_nettype none
module sag_chk
  import sag_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] query_fnum,
  input wire logic        query_ok,
  input wire logic        setup_entry_message,
  input wire logic        setup_refused_message,
  input wire logic        code_prompt,
  input wire logic [15:0] code_value,
  input wire logic        setup_open,
  input wire logic [2:0]  granted_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // --------------------------------------------------------------
  // sequences and properties
  // --------------------------------------------------------------
  sequence s_lead;  // a message or prompt came just before
    $past(setup_entry_message || code_prompt);
  endsequence
  sequence s_prompt_on;  // prompt held two cycles
    code_prompt[*2];
  endsequence
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_wait_back;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_open_lvl;
    setup_open && $past(setup_open) |-> granted_level != LVL_NONE;
  endproperty
  property p_refuse_shut;
    setup_refused_message |-> !setup_open && !code_prompt;
  endproperty
  property p_open_cause;
    $rose(setup_open) |-> s_lead;
  endproperty
  property p_code_step;
    s_prompt_on ##0 (code_value != $past(code_value)) |->
      code_value == 16'($past(code_value) + 16'h0001) ||
      code_value == 16'($past(code_value) - 16'h0001);
  endproperty
  property p_query_zero;
    (query_fnum == 16'h0000)[*3] |-> !query_ok;
  endproperty
  property p_query_shut;
    (!setup_open)[*3] |-> !query_ok;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");
  a_wait_back: assert property (p_wait_back) else $error("bus wait dropped too long");
  a_open_lvl: assert property (p_open_lvl) else $error("open without level");
  a_refuse_shut: assert property (p_refuse_shut) else $error("open while refused");
  a_open_cause: assert property (p_open_cause) else $error("open without entry");
  a_code_step: assert property (p_code_step) else $error("code moved by more than one");
  a_query_zero: assert property (p_query_zero) else $error("number zero permitted");
  a_query_shut: assert property (p_query_shut) else $error("permit while closed");
endmodule : sag_chk
bind sag_gate sag_chk i_chk (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .query_fnum,
  .query_ok, .setup_entry_message, .setup_refused_message, .code_prompt, .code_value,
  .setup_open, .granted_level);
`default_nettype wire

// ---- verification/sag_operator.sv ----
// operator model: three pushbuttons and the remote input switch
// assumes calls from the bench right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module sag_operator (
  input  wire logic clk,
  output var logic  btn_setup_entry_message,
  output var logic  btn_up,
  output var logic  btn_down,
  output var logic  remote_access_n
);
  // released buttons, switch open (pulled high)
  initial {btn_setup_entry_message, btn_up, btn_down, remote_access_n} <= 4'b0001;
  // press the chosen buttons {setup_entry_message,up,down} and keep them
  task automatic press(input logic [2:0] b);
    @(posedge clk);
    {btn_setup_entry_message, btn_up, btn_down} <= b;
  endtask : press
  // tap then let go; taps stay well inside the start window
  task automatic pulse(input logic [2:0] b, input int n);
    press(b);
    repeat (n) @(posedge clk);
    press(3'b000);
    repeat (4) @(posedge clk);
  endtask : pulse
  // short the remote input to ground or open it
  task automatic ground(input logic g);
    @(posedge clk);
    remote_access_n <= !g;
  endtask : ground
endmodule : sag_operator
`default_nettype wire

// ---- verification/setup_access_gate_bench.sv ----
// self-checking bench for the setup access gate
// assumes the operator model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module setup_access_gate_bench
  import sag_pkg::*;
;
  localparam int HOLD = 40;  // shortened hold count
  logic clk, rst, avs_read, avs_write;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [3:0]  avs_byteenable;
  logic [15:0] query_fnum, code_value;
  logic        avs_waitrequest, btn_setup_entry_message, btn_up, btn_down, remote_access_n, query_ok;
  logic        setup_entry_message, setup_refused_message, code_prompt, setup_open, irq;
  logic [2:0]  granted_level;
  int          error_cnt = 0, n_compared = 0;
  sag_gate #(.HOLD_CYC(HOLD), .WIN_CYC(40), .MSG_CYC(8)) i_dut (.clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .btn_setup_entry_message, .btn_up, .btn_down, .remote_access_n, .query_fnum, .query_ok,
    .setup_entry_message, .setup_refused_message, .code_prompt, .code_value, .setup_open,
    .granted_level, .irq);
  sag_operator i_op (.clk, .btn_setup_entry_message, .btn_up, .btn_down, .remote_access_n);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_wait();  // hold until waitrequest seen low
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
  endtask : bus_wait
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clk);  // one idle edge between requests
    avs_address   <= a;
    avs_writedata <= v;
    avs_write     <= 1'b1;
    bus_wait();
    avs_write     <= 1'b0;
  endtask : bus_wr
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk);  // one idle edge between requests
    avs_address <= a;
    avs_read    <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read    <= 1'b0;
    chk(d, exp);
  endtask : rd_chk
  task automatic wait_hi(ref logic s);  // bounded wait for a level
    int n;
    n = 0;
    while (s !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(32'(s), 32'h1);
  endtask : wait_hi
  task automatic leave();  // long hold closes setup, then settle
    i_op.press(3'b100);
    repeat (HOLD + 10) @(posedge clk);
    i_op.press(3'b000);
    repeat (100) @(posedge clk);
    chk(32'(setup_open), 32'h0);
  endtask : leave
  task automatic hold_in(input logic [2:0] lv);  // hold-to-enter route
    i_op.press(3'b100);
    wait_hi(setup_entry_message);
    i_op.press(3'b000);
    wait_hi(setup_open);
    chk(32'(granted_level), 32'(lv));
  endtask : hold_in
  task automatic pin_try(input logic [15:0] code, input logic [2:0] lv);
    bus_wr(OFS_IRQ_STAT, 32'h0000_0003);
    i_op.pulse(3'b100, 3);
    i_op.pulse(3'b011, 4);
    wait_hi(code_prompt);
    repeat (int'(code)) i_op.pulse(3'b010, 3);
    chk(32'(code_value), 32'(code));
    i_op.pulse(3'b100, 3);
    repeat (20) @(posedge clk);
    chk(32'(granted_level), 32'(lv));
    rd_chk(OFS_IRQ_STAT, (lv == LVL_NONE) ? 32'h0000_0002 : 32'h0000_0001);
    if (lv != LVL_NONE) leave();
  endtask : pin_try
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  // --------------------------------------------------------------
  // watchdog and scenarios
  // --------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    rst <= 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} <= '0;
    avs_byteenable <= 4'hf;
    query_fnum <= 16'h0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(OFS_EASY_LVL, 32'h0000_0000);
    rd_chk(OFS_RMT_LVL, 32'h0000_0000);
    rd_chk(OFS_PIN1_VAL, 32'h0000_0000);
    rd_chk(OFS_PIN2_VAL, 32'h0000_0000);
    rd_chk(OFS_OVR_BASE, 32'h0000_0000);
    rd_chk(6'h3c, 32'h0000_0000);
    bus_wr(OFS_IRQ_MASK, 32'h0000_0003);
    i_op.press(3'b100);
    wait_hi(setup_refused_message);
    i_op.press(3'b000);
    chk(32'(irq), 32'h1);
    rd_chk(OFS_IRQ_STAT, 32'h0000_0002);
    bus_wr(OFS_IRQ_STAT, 32'h0000_0002);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    repeat (100) @(posedge clk);
    bus_wr(OFS_EASY_LVL, 32'h0000_0003);
    bus_wr(OFS_IRQ_MASK, 32'h0000_0002);
    bus_wr(OFS_OVR_BASE, 32'h0007_0000);
    hold_in(3'h3);
    rd_chk(OFS_STATUS, 32'h0000_0340);
    repeat (3) @(posedge clk);
    chk(32'(query_ok), 32'h0);
    chk(32'(irq), 32'h0);
    query_fnum <= 16'h22fc;
    repeat (3) @(posedge clk);
    chk(32'(query_ok), 32'h1);
    query_fnum <= 16'h43a0;
    repeat (3) @(posedge clk);
    chk(32'(query_ok), 32'h0);
    bus_wr(OFS_OVR_BASE + 6'h04, 32'h0001_43a0);
    repeat (3) @(posedge clk);
    chk(32'(query_ok), 32'h1);
    avs_byteenable <= 4'h4;
    bus_wr(OFS_OVR_BASE + 6'h04, 32'h0000_0000);
    avs_byteenable <= 4'hf;
    repeat (3) @(posedge clk);
    chk(32'(query_ok), 32'h0);
    rd_chk(OFS_OVR_BASE + 6'h04, 32'h0000_43a0);
    leave();
    bus_wr(OFS_RMT_LVL, 32'h0000_0005);
    i_op.ground(1'b1);
    hold_in(3'h5);
    rd_chk(OFS_STATUS, 32'h0000_0d40);
    chk(32'(query_ok), 32'h1);
    i_op.ground(1'b0);
    leave();
    bus_wr(OFS_PIN1_VAL, 32'h0000_0002);
    bus_wr(OFS_PIN1_LVL, 32'h0000_0002);
    bus_wr(OFS_PIN2_VAL, 32'h0000_0003);
    bus_wr(OFS_PIN2_LVL, 32'h0000_0006);
    pin_try(16'h0003, 3'h6);
    pin_try(16'h0002, 3'h2);
    pin_try(16'h0001, LVL_NONE);
    chk(32'(setup_refused_message), 32'h0);
    complete_run();
  end
endmodule : setup_access_gate_bench
`default_nettype wire
